// ---- logic/lmie_consts.vh ----
// Opcode patterns, field positions and reset values for the move and indirect-store executor
`ifndef LMIE_CONSTS_VH
`define LMIE_CONSTS_VH
`define LMIE_OP_NO_OP      14'h0000
`define LMIE_OP_RESET      14'h0001
`define LMIE_OP_OPTION     14'h0062
`define LMIE_MASK_BANK     14'h3fe0
`define LMIE_PAT_BANK      14'h0020
`define LMIE_MASK_PAGE     14'h3f80
`define LMIE_PAT_PAGE      14'h3180
`define LMIE_MASK_ACCLIT   14'h3f00
`define LMIE_PAT_ACCLIT    14'h3000
`define LMIE_MASK_STORE    14'h3f80
`define LMIE_PAT_STORE     14'h0080
`define LMIE_MASK_INDMODE  14'h3ff8
`define LMIE_PAT_INDMODE   14'h0018
`define LMIE_MASK_INDREL   14'h3f80
`define LMIE_PAT_INDREL    14'h3f80
`define LMIE_IND_SEL_BIT   2
`define LMIE_REL_SEL_BIT   6
`define LMIE_MODE_HI       1
`define LMIE_MODE_LO       0
`define LMIE_OFS_HI        5
`define LMIE_MODE_PREINC   2'h0
`define LMIE_MODE_PREDEC   2'h1
`define LMIE_MODE_POSTINC  2'h2
`define LMIE_MODE_POSTDEC  2'h3
`define LMIE_ADDR_PORT0    7'h00
`define LMIE_ADDR_PORT1    7'h01
`define LMIE_BANK_HI       4
`define LMIE_PAGE_HI       6
`define LMIE_ACC_HI        7
`define LMIE_FADDR_HI      6
`define LMIE_FIELD_LO      0
`define LMIE_OFS_EXT       10
`define LMIE_FADDR_PAD     9'h000
`define LMIE_PULSE_OFF     1'h0
`define LMIE_PULSE_ON      1'h1
`define LMIE_RST_IND       1'h1
`define LMIE_IND_CLEAR     1'h0
`define LMIE_MINUS_ONE16   16'hffff
`define LMIE_RST_BANK      5'h00
`define LMIE_RST_PAGE      7'h00
`define LMIE_RST_ACC       8'h00
`define LMIE_RST_OPTION    8'hff
`define LMIE_RST_PTR       16'h0000
`define LMIE_RST_PC        15'h0000
`define LMIE_ONE16         16'h0001
`define LMIE_ONE15         15'h0001
`endif

// ---- logic/lmie_exec.v ----
// Executor for literal loads, accumulator moves, indirect store, no-op and software reset
`timescale 1ns/10ps
`include "lmie_consts.vh"

// How it works
// - Bank-literal loads its 0..31 operand into the 5-bit bank select and touches no flag.
// - Page-latch literal loads its 7-bit operand into the pc high latch, no flag change.
// - Accumulator-literal puts the 8-bit literal in the accumulator in one cycle, no flags.
// - Store-accumulator writes the accumulator to a 7-bit file address in one cycle.
// - Indirect store picks pointer 0 or 1 and pre/post increments or decrements it by mode.
// - Relative form writes at pointer plus signed -32..31 offset and keeps the pointer.
// - The indirect data ports redirect any access to the pointer address, no flag change.
// - Each pointer is 16 bits and wraps modulo 2^16 on increment and decrement.
// - Pointer steps never touch zero, carry or any other status bit.
// - Option-load copies the accumulator into the timer option register.
// - Software reset raises a one-cycle soft_reset_req and clears the reset indicator flag.
module lmie_exec
(
   input  wire        clk,
   input  wire        resetn,
   input  wire        instr_valid,
   input  wire [13:0] instr_word,
   input  wire        status_in_clear,
   output reg  [4:0]  bank_select_reg,
   output reg  [6:0]  pc_high_latch,
   output reg  [7:0]  accum,
   output reg  [7:0]  option_reg,
   output reg  [15:0] indirect_pointer0,
   output reg  [15:0] indirect_pointer1,
   output reg  [14:0] prog_counter,
   output reg         mem_we,
   output reg  [15:0] mem_addr,
   output reg  [7:0]  mem_wdata,
   output reg         mem_indirect,
   output reg         status_we,
   output reg         soft_reset_req,
   output reg         soft_reset_indicator
);

   wire        is_reset;
   wire        is_option;
   wire        is_bank;
   wire        is_page;
   wire        is_acclit;
   wire        is_store;
   wire        is_indmode;
   wire        is_indrel;
   wire        sel;
   wire [1:0]  mode;
   wire [15:0] ptr;
   wire [15:0] ptr_inc;
   wire [15:0] ptr_dec;
   wire [15:0] offset;
   wire [6:0]  faddr;
   wire [15:0] ptr_rel;
   reg  [15:0] next_ptr;
   reg  [15:0] ea;

   function match;
      input [13:0] word;
      input [13:0] mask;
      input [13:0] pat;
      begin
         match = ((word & mask) == pat);
      end
   endfunction

   // One 16-bit adder form for every pointer sum, so carries drop off the top
   function [15:0] ptr_add;
      input [15:0] base;
      input [15:0] delta;
      begin
         ptr_add = base + delta;
      end
   endfunction

   assign is_reset   = instr_valid && (instr_word == `LMIE_OP_RESET);
   assign is_option  = instr_valid && (instr_word == `LMIE_OP_OPTION);
   assign is_bank    = instr_valid && match(instr_word, `LMIE_MASK_BANK, `LMIE_PAT_BANK);
   assign is_page    = instr_valid && match(instr_word, `LMIE_MASK_PAGE, `LMIE_PAT_PAGE);
   assign is_acclit  = instr_valid && match(instr_word, `LMIE_MASK_ACCLIT, `LMIE_PAT_ACCLIT);
   assign is_store   = instr_valid && match(instr_word, `LMIE_MASK_STORE, `LMIE_PAT_STORE);
   assign is_indmode = instr_valid && match(instr_word, `LMIE_MASK_INDMODE, `LMIE_PAT_INDMODE);
   assign is_indrel  = instr_valid && match(instr_word, `LMIE_MASK_INDREL, `LMIE_PAT_INDREL);
   assign sel  = is_indrel ? instr_word[`LMIE_REL_SEL_BIT] : instr_word[`LMIE_IND_SEL_BIT];
   assign mode = instr_word[`LMIE_MODE_HI:`LMIE_MODE_LO];
   assign ptr  = sel ? indirect_pointer1 : indirect_pointer0;
   assign ptr_inc = ptr_add(ptr, `LMIE_ONE16);
   assign ptr_dec = ptr_add(ptr, `LMIE_MINUS_ONE16);
   // Sign-extend the 6-bit offset so negative steps wrap the same way
   assign offset  = {{`LMIE_OFS_EXT{instr_word[`LMIE_OFS_HI]}},
                     instr_word[`LMIE_OFS_HI:`LMIE_FIELD_LO]};
   assign faddr   = instr_word[`LMIE_FADDR_HI:`LMIE_FIELD_LO];
   assign ptr_rel = ptr_add(ptr, offset);

   always @*
   begin
      next_ptr = ptr;
      ea       = ptr;
      case (mode)
         `LMIE_MODE_PREINC:
         begin
            next_ptr = ptr_inc;
            ea       = ptr_inc;
         end
         `LMIE_MODE_PREDEC:
         begin
            next_ptr = ptr_dec;
            ea       = ptr_dec;
         end
         `LMIE_MODE_POSTINC:
            next_ptr = ptr_inc;
         `LMIE_MODE_POSTDEC:
            next_ptr = ptr_dec;
         default:
            next_ptr = ptr;
      endcase
      // A relative store reads the pointer but never writes it back
      // relative offset
      if (is_indrel)
      begin
         next_ptr = ptr;
         ea       = ptr_rel;
      end
   end

   // Soft reset is a one-cycle request; the system reset logic feeds it back to resetn.
   // The indicator sits outside that loop and resets only on power-up.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bank_select_reg   <= `LMIE_RST_BANK;
         pc_high_latch     <= `LMIE_RST_PAGE;
         accum             <= `LMIE_RST_ACC;
         option_reg        <= `LMIE_RST_OPTION;
         indirect_pointer0 <= `LMIE_RST_PTR;
         indirect_pointer1 <= `LMIE_RST_PTR;
         prog_counter      <= `LMIE_RST_PC;
         mem_we            <= `LMIE_PULSE_OFF;
         mem_addr          <= `LMIE_RST_PTR;
         mem_wdata         <= `LMIE_RST_ACC;
         mem_indirect      <= `LMIE_PULSE_OFF;
         status_we         <= `LMIE_PULSE_OFF;
         soft_reset_req    <= `LMIE_PULSE_OFF;
      end
      else
      begin
         // Pulses default low so that each stands for one cycle only
         mem_we         <= `LMIE_PULSE_OFF;
         mem_indirect   <= `LMIE_PULSE_OFF;
         status_we      <= `LMIE_PULSE_OFF;
         soft_reset_req <= `LMIE_PULSE_OFF;
         // Unknown words still advance the pc; the reset word holds it for the restart
         // pc advances
         if (instr_valid && !is_reset)
            prog_counter <= prog_counter + `LMIE_ONE15;
         if (is_bank)
            bank_select_reg <= instr_word[`LMIE_BANK_HI:`LMIE_FIELD_LO];
         if (is_page)
            pc_high_latch <= instr_word[`LMIE_PAGE_HI:`LMIE_FIELD_LO];
         if (is_acclit)
            accum <= instr_word[`LMIE_ACC_HI:`LMIE_FIELD_LO];
         if (is_option)
            option_reg <= accum;
         if (is_store)
         begin
            mem_we    <= `LMIE_PULSE_ON;
            mem_wdata <= accum;
            if (faddr == `LMIE_ADDR_PORT0)
            begin
               mem_addr     <= indirect_pointer0;
               mem_indirect <= `LMIE_PULSE_ON;
            end
            else if (faddr == `LMIE_ADDR_PORT1)
            begin
               mem_addr     <= indirect_pointer1;
               mem_indirect <= `LMIE_PULSE_ON;
            end
            else
               mem_addr <= {`LMIE_FADDR_PAD, faddr};
         end
         // Decoders are exclusive, so this never races the direct store above
         // indirect store and pointer step
         if (is_indmode || is_indrel)
         begin
            mem_we       <= `LMIE_PULSE_ON;
            mem_wdata    <= accum;
            mem_addr     <= ea;
            mem_indirect <= `LMIE_PULSE_ON;
            if (sel)
               indirect_pointer1 <= next_ptr;
            else
               indirect_pointer0 <= next_ptr;
         end
         if (is_reset)
            soft_reset_req <= `LMIE_PULSE_ON;
      end
   end

   // Indicator lives on a power-up style reset: it must survive the reset it reports.
   always @(posedge clk or negedge status_in_clear)
   begin
      if (!status_in_clear)
         soft_reset_indicator <= `LMIE_RST_IND;
      else if (is_reset)
         soft_reset_indicator <= `LMIE_IND_CLEAR;
   end

endmodule

// ---- testbench/lmie_exec_properties.sv ----
// Concurrent checks on the move and indirect-store executor ports
`timescale 1ns/10ps
module lmie_props
(
   input wire        clk,
   input wire        resetn,
   input wire        instr_valid,
   input wire [13:0] instr_word,
   input wire [4:0]  bank_select_reg,
   input wire [6:0]  pc_high_latch,
   input wire [7:0]  accum,
   input wire [7:0]  option_reg,
   input wire [15:0] indirect_pointer0,
   input wire [15:0] indirect_pointer1,
   input wire [14:0] prog_counter,
   input wire        mem_we,
   input wire [15:0] mem_addr,
   input wire [7:0]  mem_wdata,
   input wire        mem_indirect,
   input wire        soft_reset_req,
   input wire        soft_reset_indicator
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Idle slots map to a word that no pattern below matches
   wire [13:0] w = instr_valid ? instr_word : 14'h3b00;
   bank_load_a: assert property ((w & 14'h3fe0) == 14'h0020
      |=> bank_select_reg == $past(w[4:0])) else $error("bank load wrong");
   page_load_a: assert property ((w & 14'h3f80) == 14'h3180
      |=> pc_high_latch == $past(w[6:0])) else $error("page latch load wrong");
   acc_load_a: assert property ((w & 14'h3f00) == 14'h3000
      |=> accum == $past(w[7:0])) else $error("accum load wrong");
   file_store_a: assert property ((w & 14'h3f80) == 14'h0080 && w[6:1] != 6'h00
      |=> mem_we && !mem_indirect && mem_addr == $past({9'h000, w[6:0]})
      && mem_wdata == $past(accum)) else $error("file store wrong");
   port_redirect_a: assert property ((w & 14'h3ffe) == 14'h0080
      |=> mem_indirect && mem_addr == ($past(w[0]) ? indirect_pointer1 : indirect_pointer0))
      else $error("indirect port not redirected");
   rel_keep_a: assert property ((w & 14'h3f80) == 14'h3f80
      |=> mem_we && $stable(indirect_pointer0) && $stable(indirect_pointer1))
      else $error("relative store moved a pointer");
   pre_inc_a: assert property (w == 14'h0018
      |=> indirect_pointer0 == $past(indirect_pointer0) + 16'h0001
      && mem_addr == indirect_pointer0) else $error("pre-increment wrong");
   ptr_wrap_a: assert property (w == 14'h001f
      |=> indirect_pointer1 == $past(indirect_pointer1) - 16'h0001
      && mem_addr == $past(indirect_pointer1)) else $error("post-decrement wrong");
   option_load_a: assert property (w == 14'h0062
      |=> option_reg == $past(accum)) else $error("option load wrong");
   soft_reset_a: assert property (w == 14'h0001
      |=> soft_reset_req && !soft_reset_indicator) else $error("soft reset wrong");
   no_op_a: assert property (w == 14'h0000
      |=> prog_counter == $past(prog_counter) + 15'h0001 && !mem_we && $stable(accum))
      else $error("no-op changed state");
endmodule
bind lmie_exec lmie_props i_props
(
   .clk                  (clk),
   .resetn               (resetn),
   .instr_valid          (instr_valid),
   .instr_word           (instr_word),
   .bank_select_reg      (bank_select_reg),
   .pc_high_latch        (pc_high_latch),
   .accum                (accum),
   .option_reg           (option_reg),
   .indirect_pointer0    (indirect_pointer0),
   .indirect_pointer1    (indirect_pointer1),
   .prog_counter         (prog_counter),
   .mem_we               (mem_we),
   .mem_addr             (mem_addr),
   .mem_wdata            (mem_wdata),
   .mem_indirect         (mem_indirect),
   .soft_reset_req       (soft_reset_req),
   .soft_reset_indicator (soft_reset_indicator)
);

// ---- testbench/test_lmie_exec.sv ----
// Self-checking bench for the move and indirect-store executor
`timescale 1ns/10ps
module test_lmie_exec;
   localparam [223:0] DIRS = {14'h30a5, 14'h002f, 14'h31ff, 14'h0062, 14'h0019, 14'h0018,
      14'h001f, 14'h001e, 14'h001a, 14'h001d, 14'h3fa0, 14'h3fdf, 14'h0080, 14'h0081,
      14'h00ff, 14'h2000};
   localparam [111:0] BASES = {14'h0000, 14'h3f80, 14'h0018, 14'h0080, 14'h0062, 14'h3180,
      14'h0020, 14'h3000};
   localparam [111:0] FLDS = {14'h0000, 14'h007f, 14'h0007, 14'h007f, 14'h0000, 14'h007f,
      14'h000f, 14'h00ff};
   reg         clk = 1'h0;
   reg         resetn = 1'h0;
   reg         instr_valid = 1'h0;
   reg  [13:0] instr_word = 14'h0000;
   reg         status_in_clear = 1'h0;
   wire [4:0]  bank_select_reg;
   wire [6:0]  pc_high_latch;
   wire [7:0]  accum, option_reg, mem_wdata;
   wire [15:0] indirect_pointer0, indirect_pointer1, mem_addr;
   wire [14:0] prog_counter;
   wire        mem_we, mem_indirect, status_we, soft_reset_req, soft_reset_indicator;
   integer     n_fail = 0;
   integer     total_checks = 0;
   integer     seed = 83;
   integer     i, r, rv;
   reg  [15:0] p [0:1];
   reg  [15:0] a, d;
   reg  [7:0]  e_acc, e_opt, e_wd;
   reg  [4:0]  e_bank;
   reg  [6:0]  e_page;
   reg  [14:0] e_pc;
   reg         e_we, e_ind, e_req;
   reg         e_ri = 1'h1;
   lmie_exec i_dut
   (
      .clk                  (clk),
      .resetn               (resetn),
      .instr_valid          (instr_valid),
      .instr_word           (instr_word),
      .status_in_clear      (status_in_clear),
      .bank_select_reg      (bank_select_reg),
      .pc_high_latch        (pc_high_latch),
      .accum                (accum),
      .option_reg           (option_reg),
      .indirect_pointer0    (indirect_pointer0),
      .indirect_pointer1    (indirect_pointer1),
      .prog_counter         (prog_counter),
      .mem_we               (mem_we),
      .mem_addr             (mem_addr),
      .mem_wdata            (mem_wdata),
      .mem_indirect         (mem_indirect),
      .status_we            (status_we),
      .soft_reset_req       (soft_reset_req),
      .soft_reset_indicator (soft_reset_indicator)
   );
   initial
   begin
      forever #50 clk = ~clk;
   end
   task report_and_stop;
      begin
         if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp)
         begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task cmp;
      begin
         chk(bank_select_reg, e_bank);
         chk(pc_high_latch, e_page);
         chk(accum, e_acc);
         chk(option_reg, e_opt);
         chk(indirect_pointer0, p[0]);
         chk(indirect_pointer1, p[1]);
         chk(prog_counter, e_pc);
         chk({mem_we, mem_indirect, soft_reset_req}, {e_we, e_ind, e_req});
         if (e_we)
            chk({mem_addr, mem_wdata}, {a, e_wd});
         chk({status_we, soft_reset_indicator}, {1'h0, e_ri});
      end
   endtask
   // Each call checks the result of the word issued one edge earlier
   task step(input [13:0] x);
      begin
         @(posedge clk);
         instr_valid <= 1'h1;
         instr_word <= x;
         #1 cmp;
         {e_we, e_ind, e_req, e_wd} = {3'h0, e_acc};
         e_pc = e_pc + 15'h0001;
         if (x == 14'h0001)
            {e_req, e_ri, e_pc} = {2'h2, e_pc - 15'h0001};
         else if (x == 14'h0062)
            e_opt = e_acc;
         else if ((x & 14'h3fe0) == 14'h0020)
            e_bank = x[4:0];
         else if ((x & 14'h3f80) == 14'h3180)
            e_page = x[6:0];
         else if ((x & 14'h3f00) == 14'h3000)
            e_acc = x[7:0];
         else if ((x & 14'h3f80) == 14'h0080)
            {e_we, e_ind, a} = {1'h1, x[6:1] == 6'h00,
               x[6:1] == 6'h00 ? p[x[0]] : {9'h000, x[6:0]}};
         else if ((x & 14'h3f80) == 14'h3f80)
            {e_we, e_ind, a} = {2'h3, p[x[6]] + {{10{x[5]}}, x[5:0]}};
         else if ((x & 14'h3ff8) == 14'h0018)
         begin
            // Pointer steps wrap through 16-bit arithmetic
            d = x[0] ? 16'hffff : 16'h0001;
            p[x[2]] = x[1] ? p[x[2]] : p[x[2]] + d;
            {e_we, e_ind, a} = {2'h3, p[x[2]]};
            p[x[2]] = x[1] ? p[x[2]] + d : p[x[2]];
         end
      end
   endtask
   task rst;
      begin
         @(posedge clk);
         instr_valid <= 1'h0;
         resetn <= 1'h0;
         {e_bank, e_page, e_acc, e_opt, e_pc, e_we, e_ind, e_req} = {28'h00000ff, 18'h0};
         p[0] = 16'h0000;
         p[1] = 16'h0000;
         repeat (3) @(posedge clk);
         resetn <= 1'h1;
         status_in_clear <= 1'h1;
      end
   endtask
   initial
   begin
      rst;
      for (i = 0; i < 16; i = i + 1)
         step(DIRS[(15 - i) * 14 +: 14]);
      for (i = 0; i < 300; i = i + 1)
      begin
         r = $random(seed) & 7;
         rv = $random(seed);
         step(BASES[r * 14 +: 14] | (rv[13:0] & FLDS[r * 14 +: 14]));
      end
      step(14'h0001);
      step(14'h0000);
      rst;
      step(14'h0000);
      step(14'h0000);
      report_and_stop;
   end
   initial
   begin
      #100000;
      n_fail = n_fail + 1;
      report_and_stop;
   end
endmodule
